// >>> uart_pwr_defines.svh
`ifndef UART_PWR_DEFINES_SVH
`define UART_PWR_DEFINES_SVH

// character times of idle receive line needed before sleep
`define RX_IDLE_CHARS 3'h4
// idle counter reset value
`define RX_IDLE_ZERO 3'h0
// width of the modem input group
`define MODEM_W 4
// reset value of the modem input history
`define MODEM_ZERO 4'h0
// reset value of a character lane
`define BYTE_ZERO 8'h00

`endif

// >>> uart_pwr_pkg.sv
package uart_pwr_pkg;

  typedef enum logic [1:0] {
    st_awake,
    st_sleep,
    st_low_power
  } power_state_type;

endpackage

// >>> uart_sleep_rs485_ctrl.sv
`timescale 1ns/100ps
`include "uart_pwr_defines.svh"

// Behaviour
// - sleep needs enhanced bit and sleep enable
// - sleep needs idle modem, line, fifos, interrupts
// - ignore-receive bit drops idle line condition
// - uart clock enable drops asleep
// - start bit, fifo write, modem change wake
// - re-enter sleep until sleep enable cleared
// - low power pin forces stop, until released
// - rts follows modem bit or flow control
// - auto direction bit overrides other rts sources
// - auto mode: low on write, high after last
// - invert bit flips auto direction polarity
// - multidrop bit: parity one marks address
// - receiver off: drop data, flag address, store
// - receiver on: accept data, flag next address
// - auto detect drops foreign addresses, and data while receiver off
// - matching address enables receiver, stored, flagged
// - foreign address disables receiver while active
module uart_sleep_rs485_ctrl (
  input wire logic i_core_clk,
  input wire logic i_reset,
  input wire logic i_clk_en,
  input wire logic i_enh_func_en,
  input wire logic i_sleep_en,
  input wire logic i_line_int_en,
  input wire logic i_rx_idle_ignore,
  input wire logic i_auto_rts_en,
  input wire logic i_rts_invert,
  input wire logic i_multidrop_en,
  input wire logic i_special_char_en,
  input wire logic [7:0] i_addr_char,
  input wire logic i_mcr_rts,
  input wire logic i_hw_flow_en,
  input wire logic i_flow_rts_n,
  input wire logic i_low_power_pin,
  input wire logic [3:0] i_modem_in,
  input wire logic i_rx_in,
  input wire logic i_char_tick,
  input wire logic i_tx_write,
  input wire logic i_tx_last_bit_done,
  input wire logic i_tx_empty,
  input wire logic i_int_pending,
  input wire logic i_rx_fifo_empty,
  input wire logic i_rx_valid,
  input wire logic [7:0] i_rx_data,
  input wire logic i_rx_parity,
  input wire logic i_rx_parity_err,
  input wire logic i_rx_enable_set,
  input wire logic i_rx_enable_clr,
  output logic o_sleep,
  output logic o_low_power,
  output logic o_uart_clk_en,
  output logic o_wake_start,
  output logic o_rts_n,
  output logic o_push_valid,
  output logic [7:0] o_push_data,
  output logic o_push_parity_err,
  output logic o_line_status_int,
  output logic o_rx_enabled
);

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic lp_meta_q;
  logic lp_sync_q;
  logic rx_meta_q;
  logic rx_sync_q;
  logic rx_prev_q;
  logic [`MODEM_W-1:0] modem_meta_q;
  logic [`MODEM_W-1:0] modem_sync_q;
  logic [`MODEM_W-1:0] modem_prev_q;

  // only the second stage and its delayed copy are read by any logic
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      lp_meta_q <= 1'b0;
      lp_sync_q <= 1'b0;
      rx_meta_q <= 1'b1;
      rx_sync_q <= 1'b1;
      rx_prev_q <= 1'b1;
    end else if (i_clk_en) begin
      lp_meta_q <= i_low_power_pin;
      lp_sync_q <= lp_meta_q;
      rx_meta_q <= i_rx_in;
      rx_sync_q <= rx_meta_q;
      rx_prev_q <= rx_sync_q;
    end
  end

  genvar g;
  generate
    for (g = 0; g < `MODEM_W; g = g + 1) begin : g_modem_sync
      always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
          modem_meta_q[g] <= 1'b0;
          modem_sync_q[g] <= 1'b0;
          modem_prev_q[g] <= 1'b0;
        end else if (i_clk_en) begin
          modem_meta_q[g] <= i_modem_in[g];
          modem_sync_q[g] <= modem_meta_q[g];
          modem_prev_q[g] <= modem_sync_q[g];
        end
      end
    end
  endgenerate

  logic modem_change;
  logic rx_start_edge;

  assign modem_change = (modem_sync_q != modem_prev_q);
  assign rx_start_edge = rx_prev_q & ~rx_sync_q;

  // ----------------------------------------------------------------
  // receive line idle timer
  // ----------------------------------------------------------------
  logic [2:0] idle_cnt_q;
  logic rx_idle;

  // counts character times of steady high line; any low restarts
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      idle_cnt_q <= `RX_IDLE_ZERO;
    end else if (i_clk_en) begin
      if (!rx_sync_q) begin
        idle_cnt_q <= `RX_IDLE_ZERO;
      end else if (i_char_tick && idle_cnt_q != `RX_IDLE_CHARS) begin
        idle_cnt_q <= idle_cnt_q + 3'h1;
      end
    end
  end

  assign rx_idle = (idle_cnt_q == `RX_IDLE_CHARS)
                 | i_rx_idle_ignore;

  // ----------------------------------------------------------------
  // sleep and low power control
  // ----------------------------------------------------------------
  logic sleep_allowed;
  logic sleep_ready;
  logic wake_event;
  uart_pwr_pkg::power_state_type state_q;

  assign sleep_allowed = i_enh_func_en & i_sleep_en;
  assign sleep_ready = ~modem_change & rx_idle & i_tx_empty
                     & ~i_int_pending & i_rx_fifo_empty;
  assign wake_event = rx_start_edge | i_tx_write | modem_change;

  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      state_q <= uart_pwr_pkg::st_awake;
    end else if (i_clk_en) begin
      case (state_q)
        uart_pwr_pkg::st_awake: begin
          if (lp_sync_q) begin
            state_q <= uart_pwr_pkg::st_low_power;
          end else if (sleep_allowed && sleep_ready && !wake_event) begin
            state_q <= uart_pwr_pkg::st_sleep;
          end
        end
        uart_pwr_pkg::st_sleep: begin
          if (lp_sync_q) begin
            state_q <= uart_pwr_pkg::st_low_power;
          end else if (wake_event || !sleep_allowed) begin
            state_q <= uart_pwr_pkg::st_awake;
          end
        end
        uart_pwr_pkg::st_low_power: begin
          if (!lp_sync_q) begin
            state_q <= uart_pwr_pkg::st_awake;
          end
        end
        default: begin
          state_q <= uart_pwr_pkg::st_awake;
        end
      endcase
    end
  end

  // outputs registered alongside state so they track it exactly
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      o_sleep <= 1'b0;
      o_low_power <= 1'b0;
      o_uart_clk_en <= 1'b1;
    end else if (i_clk_en) begin
      case (state_q)
        uart_pwr_pkg::st_awake: begin
          o_low_power <= lp_sync_q;
          o_sleep <= ~lp_sync_q & sleep_allowed & sleep_ready
                   & ~wake_event;
          o_uart_clk_en <= ~lp_sync_q
                         & ~(sleep_allowed & sleep_ready & ~wake_event);
        end
        uart_pwr_pkg::st_sleep: begin
          o_low_power <= lp_sync_q;
          o_sleep <= ~lp_sync_q & ~wake_event & sleep_allowed;
          o_uart_clk_en <= ~lp_sync_q
                         & (wake_event | ~sleep_allowed);
        end
        uart_pwr_pkg::st_low_power: begin
          o_low_power <= lp_sync_q;
          o_sleep <= 1'b0;
          o_uart_clk_en <= ~lp_sync_q;
        end
        default: begin
          o_low_power <= 1'b0;
          o_sleep <= 1'b0;
          o_uart_clk_en <= 1'b1;
        end
      endcase
    end
  end

  // the receiver samples its start bit after clocks restart; this flag
  // tells it the falling edge already happened so it is not lost
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      o_wake_start <= 1'b0;
    end else if (i_clk_en) begin
      o_wake_start <= (state_q == uart_pwr_pkg::st_sleep)
                    & rx_start_edge & ~lp_sync_q;
    end
  end

  // ----------------------------------------------------------------
  // transmit direction control
  // ----------------------------------------------------------------
  logic tx_pending_q;

  // a write in the same cycle as the last bit keeps the driver on
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      tx_pending_q <= 1'b0;
    end else if (i_clk_en) begin
      if (i_tx_write) begin
        tx_pending_q <= 1'b1;
      end else if (i_tx_last_bit_done) begin
        tx_pending_q <= 1'b0;
      end
    end
  end

  logic auto_pending;
  assign auto_pending = i_tx_write | tx_pending_q;

  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      o_rts_n <= 1'b1;
    end else if (i_clk_en) begin
      if (i_auto_rts_en) begin
        if (i_rts_invert) begin
          o_rts_n <= auto_pending;
        end else begin
          o_rts_n <= ~auto_pending;
        end
      end else if (i_hw_flow_en) begin
        o_rts_n <= i_flow_rts_n;
      end else begin
        o_rts_n <= ~i_mcr_rts;
      end
    end
  end

  // ----------------------------------------------------------------
  // multidrop address filter
  // ----------------------------------------------------------------
  logic is_addr;
  logic addr_match;
  logic auto_detect;

  assign is_addr = i_multidrop_en & i_rx_parity;
  assign addr_match = (i_rx_data == i_addr_char);
  assign auto_detect = i_multidrop_en & i_special_char_en;

  // hardware enable or disable wins over a host pulse in the same cycle
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      o_rx_enabled <= 1'b0;
    end else if (i_clk_en) begin
      if (i_rx_valid && auto_detect && is_addr) begin
        o_rx_enabled <= addr_match;
      end else if (i_rx_enable_set) begin
        o_rx_enabled <= 1'b1;
      end else if (i_rx_enable_clr) begin
        o_rx_enabled <= 1'b0;
      end
    end
  end

  logic keep;
  logic flag_pe;

  always_comb begin
    keep = 1'b1;
    flag_pe = i_rx_parity_err;
    if (i_multidrop_en) begin
      if (auto_detect) begin
        keep = is_addr ? addr_match : o_rx_enabled;
        flag_pe = is_addr;
      end else begin
        keep = is_addr | o_rx_enabled;
        flag_pe = is_addr;
      end
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      o_push_valid <= 1'b0;
      o_push_data <= `BYTE_ZERO;
      o_push_parity_err <= 1'b0;
      o_line_status_int <= 1'b0;
    end else if (i_clk_en) begin
      o_push_valid <= i_rx_valid & keep;
      o_line_status_int <= i_rx_valid & keep & flag_pe
                         & i_line_int_en;
      if (i_rx_valid && keep) begin
        o_push_data <= i_rx_data;
        o_push_parity_err <= flag_pe;
      end
    end
  end

endmodule // uart_sleep_rs485_ctrl

// >>> uart_pwr_monitor.sv
`timescale 1ns/100ps
// ---
// sleep, direction and address filter checks
// ---
module uart_pwr_monitor (
  input wire logic i_core_clk,
  input wire logic i_reset,
  input wire logic i_enh_func_en,
  input wire logic i_sleep_en,
  input wire logic i_auto_rts_en,
  input wire logic i_rts_invert,
  input wire logic i_multidrop_en,
  input wire logic i_special_char_en,
  input wire logic [7:0] i_addr_char,
  input wire logic i_mcr_rts,
  input wire logic i_hw_flow_en,
  input wire logic i_low_power_pin,
  input wire logic i_tx_write,
  input wire logic i_rx_valid,
  input wire logic [7:0] i_rx_data,
  input wire logic i_rx_parity,
  input wire logic o_sleep,
  input wire logic o_low_power,
  input wire logic o_uart_clk_en,
  input wire logic o_rts_n,
  input wire logic o_push_valid,
  input wire logic o_push_parity_err,
  input wire logic o_rx_enabled
);
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (i_reset);
  logic addr_in;
  logic hit;
  assign addr_in = i_rx_valid && i_multidrop_en && i_rx_parity;
  assign hit = addr_in && i_special_char_en && i_rx_data == i_addr_char;
  a_sleep_needs_en: assert property (
    $rose(o_sleep) |-> $past(i_enh_func_en && i_sleep_en))
    else $error("sleep entered while disabled");
  a_clocks_stopped: assert property (
    o_sleep || o_low_power |-> !o_uart_clk_en)
    else $error("uart clock runs while stopped");
  a_write_wakes: assert property (
    o_sleep && i_tx_write |-> ##[1:2] !o_sleep)
    else $error("fifo write did not wake");
  a_low_power_pin: assert property (
    $rose(o_low_power) |-> $past(i_low_power_pin, 3))
    else $error("low power without pin");
  a_rts_on_write: assert property (
    i_auto_rts_en && i_tx_write |=> o_rts_n == $past(i_rts_invert))
    else $error("auto direction not driven on write");
  a_rts_manual: assert property (
    !i_auto_rts_en && !i_hw_flow_en |=> o_rts_n != $past(i_mcr_rts))
    else $error("rts does not follow modem bit");
  a_addr_flagged: assert property (
    addr_in && !i_special_char_en |=> o_push_valid && o_push_parity_err)
    else $error("address byte not stored flagged");
  a_foreign_drop: assert property (
    addr_in && i_special_char_en && !hit |=> !o_push_valid && !o_rx_enabled)
    else $error("foreign address not dropped");
  a_match_stored: assert property (
    hit |=> o_push_valid && o_push_parity_err && o_rx_enabled)
    else $error("matching address not stored");
  c_sleep: cover property ($rose(o_sleep));
  c_low_power: cover property ($rose(o_low_power));
  c_match: cover property (hit ##1 o_rx_enabled);
endmodule // uart_pwr_monitor

bind uart_sleep_rs485_ctrl uart_pwr_monitor mon (.*);

// >>> remote_station.sv
`timescale 1ns/100ps
// ---
// remote station on the shared line
// ---
module remote_station (
  input wire logic i_core_clk,
  output logic o_rx_line,
  output logic o_rx_valid,
  output logic [7:0] o_rx_data,
  output logic o_rx_parity
);
  initial {o_rx_line, o_rx_valid, o_rx_data, o_rx_parity} = 11'h400;
  // ninth bit set marks an address character
  task automatic send(input logic [7:0] v, input logic p);
    @(posedge i_core_clk) #1 o_rx_line = 1'b0;
    repeat (6) @(posedge i_core_clk);
    #1 {o_rx_line, o_rx_valid, o_rx_data, o_rx_parity} = {2'h3, v, p};
    @(posedge i_core_clk) #1 o_rx_valid = 1'b0;
    // lane released: show junk, not stale data
    {o_rx_data, o_rx_parity} = {~v, ~p};
  endtask
endmodule // remote_station

// >>> testbench.sv
`timescale 1ns/100ps
module testbench;
  logic i_core_clk, i_reset, i_clk_en, i_enh_func_en, i_sleep_en;
  logic i_line_int_en, i_rx_idle_ignore, i_auto_rts_en, i_rts_invert;
  logic i_multidrop_en, i_special_char_en, i_mcr_rts, i_hw_flow_en;
  logic i_flow_rts_n, i_low_power_pin, i_rx_in, i_char_tick, i_tx_write;
  logic i_tx_last_bit_done, i_tx_empty, i_int_pending, i_rx_fifo_empty;
  logic i_rx_valid, i_rx_parity, i_rx_parity_err, i_rx_enable_set;
  logic i_rx_enable_clr, o_sleep, o_low_power, o_uart_clk_en, o_wake_start;
  logic o_rts_n, o_push_valid, o_push_parity_err, o_line_status_int;
  logic o_rx_enabled;
  logic [7:0] i_addr_char, i_rx_data, o_push_data, a, d;
  logic [3:0] i_modem_in;
  logic [9:0] got;
  logic [9:0] exp_q[$];
  int n_errors = 0;
  int samples_checked = 0;
  int cycles = 0;
  int n_wake = 0;
  uart_sleep_rs485_ctrl dut (.*);
  remote_station rs (.i_core_clk, .o_rx_line(i_rx_in),
    .o_rx_valid(i_rx_valid), .o_rx_data(i_rx_data),
    .o_rx_parity(i_rx_parity));
  initial begin
    i_core_clk = 1'b0;
    forever #2 i_core_clk = ~i_core_clk;
  end
  task automatic chk(string nm, logic [9:0] e, logic [9:0] g);
    samples_checked++;
    if (g !== e) begin
      n_errors++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic wrap_up();
    if (n_errors == 0 && samples_checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic cyc(int n);
    repeat (n) @(posedge i_core_clk);
    #1;
  endtask
  task automatic ticks(int n);
    i_char_tick = 1'b1;
    cyc(n);
    i_char_tick = 1'b0;
  endtask
  task automatic wait_sleep(logic e, string nm);
    int k;
    k = 0;
    while (o_sleep !== e && k < 40) begin
      cyc(1);
      k++;
    end
    chk(nm, e, o_sleep);
  endtask
  task automatic rx(logic [7:0] v, logic p, logic keep, logic irq);
    if (keep) exp_q.push_back({irq, p, v});
    i_rx_parity_err = p;
    rs.send(v, p);
  endtask
  // ---
  // result watcher and hang guard
  // ---
  always @(posedge i_core_clk) begin
    cycles++;
    if (o_wake_start === 1'b1) n_wake++;
    if (o_push_valid === 1'b1) begin
      got = {o_line_status_int, o_push_parity_err, o_push_data};
      if (exp_q.size() == 0) chk("extra_push", 10'h000, 10'h001);
      else chk("push", exp_q.pop_front(), got);
    end
    // hang guard last, so nothing in this process follows the finish
    if (cycles == 5000) begin
      n_errors++;
      wrap_up();
    end
  end
  initial begin
    {i_clk_en, i_enh_func_en, i_rx_fifo_empty, i_tx_empty, i_reset} = 5'h1f;
    {i_sleep_en, i_line_int_en, i_rx_idle_ignore, i_auto_rts_en} = 4'h0;
    {i_rts_invert, i_multidrop_en, i_special_char_en, i_mcr_rts} = 4'h0;
    {i_hw_flow_en, i_flow_rts_n, i_low_power_pin, i_char_tick} = 4'h4;
    {i_tx_write, i_tx_last_bit_done, i_int_pending} = 3'h0;
    {i_rx_parity_err, i_rx_enable_set, i_rx_enable_clr} = 3'h0;
    {i_modem_in, i_addr_char} = 12'h000;
    void'($urandom(59521));
    cyc(8);
    i_reset = 1'b0;
    ticks(5);
    chk("sleep_off", 1'b0, o_sleep);
    i_sleep_en = 1'b1;
    wait_sleep(1'b1, "sleep_on");
    chk("clk_stop", 1'b0, o_uart_clk_en);
    {i_tx_write, i_tx_empty} = 2'h2;
    cyc(1);
    i_tx_write = 1'b0;
    wait_sleep(1'b0, "wake_tx");
    i_tx_empty = 1'b1;
    ticks(4);
    wait_sleep(1'b1, "resleep");
    rx(8'h5a, 1'b0, 1'b1, 1'b0);
    wait_sleep(1'b0, "wake_rx");
    chk("wake_start", 10'h001, 10'(n_wake));
    // first tick is lost while the line resyncs: count ends one short
    ticks(4);
    cyc(1);
    chk("idle3", 1'b0, o_sleep);
    i_rx_idle_ignore = 1'b1;
    wait_sleep(1'b1, "ignore_rx");
    {i_rx_idle_ignore, i_int_pending} = 2'h1;
    i_modem_in = 4'($urandom_range(1, 15));
    wait_sleep(1'b0, "wake_modem");
    ticks(4);
    chk("int_block", 1'b0, o_sleep);
    i_int_pending = 1'b0;
    wait_sleep(1'b1, "resleep_int");
    i_low_power_pin = 1'b1;
    cyc(5);
    chk("lp_on", 1'b1, o_low_power);
    i_low_power_pin = 1'b0;
    cyc(5);
    chk("lp_off", 1'b0, o_low_power);
    i_sleep_en = 1'b0; // host clears sleep enable before divisors
    wait_sleep(1'b0, "sleep_clr");
    for (int m = 0; m < 4; m++) begin
      {i_auto_rts_en, i_rts_invert} = {m[1], m[1] & m[0]};
      i_hw_flow_en = (m == 1); // flow control off in auto mode
      repeat (4) begin
        {i_mcr_rts, i_flow_rts_n} = 2'($urandom);
        i_tx_write = m[1];
        i_tx_last_bit_done = 1'($urandom);
        cyc(1);
        if (m < 2)
          chk("rts", m ? i_flow_rts_n : !i_mcr_rts, o_rts_n);
        else chk("rts_on", i_rts_invert, o_rts_n);
        {i_tx_write, i_tx_last_bit_done} = {1'b0, m[1]};
        // pending flag drops on the first edge, the pin on the second
        cyc(2);
        if (m > 1) chk("rts_off", !i_rts_invert, o_rts_n);
        i_tx_last_bit_done = 1'b0;
      end
    end
    i_auto_rts_en = 1'b0;
    rx(8'($urandom), 1'($urandom), 1'b1, 1'b0);
    // all flow control and special detect stay off here
    {i_multidrop_en, i_line_int_en} = 2'h3;
    {a, d} = 16'($urandom);
    rx(d, 1'b0, 1'b0, 1'b0);
    rx(a, 1'b1, 1'b1, 1'b1);
    i_rx_enable_set = 1'b1; // own address seen: enable receiver
    cyc(1);
    i_rx_enable_set = 1'b0;
    rx(d, 1'b0, 1'b1, 1'b0);
    rx(a, 1'b1, 1'b1, 1'b1);
    {i_rx_enable_clr, i_special_char_en, i_addr_char} = {2'h3, a};
    cyc(1);
    i_rx_enable_clr = 1'b0;
    rx(a ^ 8'h01, 1'b1, 1'b0, 1'b0);
    rx(d, 1'b0, 1'b0, 1'b0);
    rx(a, 1'b1, 1'b1, 1'b1);
    chk("rx_on", 1'b1, o_rx_enabled);
    rx(d, 1'b0, 1'b1, 1'b0);
    rx(a ^ 8'h80, 1'b1, 1'b0, 1'b0);
    chk("rx_off", 1'b0, o_rx_enabled);
    rx(d, 1'b0, 1'b0, 1'b0);
    cyc(4);
    chk("queue", 10'h000, 10'(exp_q.size()));
    chk("wake_count", 10'h001, 10'(n_wake));
    wrap_up();
  end
endmodule // testbench
